// ===== hdl/bbar_addr_map.sv
// Address classifier and alias-to-bit-band translator.
// Purely combinational; the caller registers whatever it keeps.
`timescale 1ns/1ps
`default_nettype none

module bbar_addr_map (
    input  wire logic [31:0] addr,       // Master address
    input  wire logic [1:0]  size,       // Master access size
    output logic             sram_alias, // Address in SRAM alias window
    output logic             peri_alias, // Address in peripheral alias window
    output logic [31:0]      tgt_addr,   // Bit-band address, aligned to size
    output logic [4:0]       bit_pos     // Bit index within the data word
);

    // Window test, used for both alias windows
    function automatic logic in_win(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction

    wire logic        sram_hit;  // SRAM alias hit
    wire logic        peri_hit;  // Peripheral alias hit
    wire logic [31:0] al_base;   // Base of the alias window hit
    wire logic [31:0] bb_base;   // Base of the matching bit-band region
    wire logic [31:0] al_ofs;    // Offset into alias window
    wire logic [31:0] byte_ofs;  // Bit-band byte offset
    wire logic [31:0] byte_addr; // Bit-band byte address
    wire logic [2:0]  bit_num;   // Bit number 0-7

    assign sram_hit  = in_win(addr, bbar_pkg::SRAM_AL_BASE, bbar_pkg::SRAM_AL_END);
    assign peri_hit  = in_win(addr, bbar_pkg::PERI_AL_BASE, bbar_pkg::PERI_AL_END);
    assign al_base   = peri_hit ? bbar_pkg::PERI_AL_BASE : bbar_pkg::SRAM_AL_BASE;
    assign bb_base   = peri_hit ? bbar_pkg::PERI_BB_BASE : bbar_pkg::SRAM_BB_BASE;

    // Inverse of offset = byte*32 + bit*4
    assign al_ofs    = addr - al_base;
    assign byte_ofs  = al_ofs >> bbar_pkg::BYTE_OFS_LSB;
    assign bit_num   = al_ofs[bbar_pkg::BIT_NUM_LSB +: bbar_pkg::BIT_NUM_W];
    assign byte_addr = bb_base + byte_ofs;

    // Align down to the access size so the underlying access keeps it
    assign tgt_addr  = (size == bbar_pkg::SIZE_WORD) ? {byte_addr[31:2], 2'h0} :
                       (size == bbar_pkg::SIZE_HALF) ? {byte_addr[31:1], 1'h0} : byte_addr;

    // Little-endian lane: byte n of a word is bits 8n+7..8n
    assign bit_pos    = {byte_addr[1:0], bit_num};
    assign sram_alias = sram_hit;
    assign peri_alias = peri_hit;

endmodule

`default_nettype wire

// ===== hdl/bbar_remap.sv
// Bit-band alias remapper between the core data bus and the memory slaves.
// Assumes a held-request master port and a held-request slave port with one-cycle acks.
//
// Overview of operation
// - SRAM alias data accesses hit bit-band bits
// - SRAM alias instruction fetches pass unmapped
// - Peripheral bit-band plain accesses forwarded unchanged
// - Peripheral alias data remapped, fetches refused
// - Alias write is read, modify, write back
// - Alias offset equals byte*32 plus bit*4
// - Bit index selects one of eight bits
// - Written bit 0 sets or clears target
// - Written bits 31:1 are ignored
// - Alias read returns zero or one
// - Memory is little-endian byte addressed
// - Underlying access keeps original access size
// - SRAM bit-band plain accesses forwarded unchanged
`timescale 1ns/1ps
`default_nettype none

module bbar_remap (
    input  wire logic        clock,       // System clock, 50 MHz
    input  wire logic        rst_n,       // Synchronous reset, active low
    input  wire logic        ce,          // Clock enable, freezes all state when low
    input  wire logic        m_req,       // Master request, held until m_done
    input  wire logic        m_write,     // Master write
    input  wire logic        m_fetch,     // Instruction fetch
    input  wire logic [1:0]  m_size,      // Access size
    input  wire logic [31:0] m_addr,      // Byte address
    input  wire logic [31:0] m_wdata,     // Write data
    output logic             m_done,      // One-cycle completion pulse
    output logic             m_err,       // Completion is an error
    output logic [31:0]      m_rdata,     // Read data, valid with m_done
    output logic             s_req,       // Slave request, held until s_ack
    output logic             s_write,     // Slave write
    output logic             s_lock,      // Read-modify-write in progress
    output logic [1:0]       s_size,      // Slave size
    output logic [31:0]      s_addr,      // Slave address
    output logic [31:0]      s_wdata,     // Slave write data
    input  wire logic        s_ack,       // Slave completion pulse
    input  wire logic [31:0] s_rdata      // Slave read data, valid with s_ack
);

    // Registered state and outputs
    bbar_pkg::bbar_state_t state_reg, state_next;     // Controller state
    logic        m_done_reg,  m_done_next;            // Done pulse
    logic        m_err_reg,   m_err_next;             // Error flag
    logic [31:0] m_rdata_reg, m_rdata_next;           // Read data to master
    logic        s_req_reg,   s_req_next;             // Slave request
    logic        s_write_reg, s_write_next;           // Slave direction
    logic        s_lock_reg,  s_lock_next;            // Locked sequence marker
    logic [1:0]  s_size_reg,  s_size_next;            // Slave size
    logic [31:0] s_addr_reg,  s_addr_next;            // Slave address
    logic [31:0] s_wdata_reg, s_wdata_next;           // Slave write data
    logic [4:0]  bitpos_reg,  bitpos_next;            // Target bit in data word
    logic        wbit_reg,    wbit_next;              // Bit value to store
    logic        alwr_reg,    alwr_next;              // Alias access is a write

    // Mapper outputs
    logic        sram_alias;                          // SRAM alias hit
    logic        peri_alias;                          // Peripheral alias hit
    logic [31:0] tgt_addr;                            // Bit-band address
    logic [4:0]  bit_pos;                             // Bit within word

    bbar_addr_map u_map (
        .addr       (m_addr),
        .size       (m_size),
        .sram_alias (sram_alias),
        .peri_alias (peri_alias),
        .tgt_addr   (tgt_addr),
        .bit_pos    (bit_pos)
    );

    // Decode of the request being taken
    wire logic accept;      // New request taken this cycle
    wire logic refuse;      // Fetch from peripheral alias
    wire logic do_alias;    // Data access to an alias window
    wire logic rd_bit;      // Bit read back from the slave
    wire logic [31:0] rmw;  // Read data with the one bit replaced

    // Done is still high in the cycle the master sees it, so skip that cycle
    assign accept   = (state_reg == bbar_pkg::BBAR_IDLE) && m_req && !m_done_reg;
    assign refuse   = m_fetch && peri_alias;
    // Fetches never take the alias path, so SRAM alias fetches stay plain
    assign do_alias = !m_fetch && (sram_alias || peri_alias);
    assign rd_bit   = s_rdata[bitpos_reg];
    // Only the addressed bit changes, all others are written back as read
    assign rmw      = wbit_reg ? (s_rdata | (32'h0000_0001 << bitpos_reg))
                               : (s_rdata & ~(32'h0000_0001 << bitpos_reg));

    // Next-state logic
    always_comb begin
        state_next   = state_reg;
        m_done_next  = 1'b0;
        m_err_next   = 1'b0;
        m_rdata_next = m_rdata_reg;
        s_req_next   = s_req_reg;
        s_write_next = s_write_reg;
        s_lock_next  = s_lock_reg;
        s_size_next  = s_size_reg;
        s_addr_next  = s_addr_reg;
        s_wdata_next = s_wdata_reg;
        bitpos_next  = bitpos_reg;
        wbit_next    = wbit_reg;
        alwr_next    = alwr_reg;
        case (state_reg)
            bbar_pkg::BBAR_IDLE: begin
                if (accept && refuse) begin
                    // Refused fetch ends at once, slave untouched
                    m_done_next = 1'b1;
                    m_err_next  = 1'b1;
                end else if (accept && do_alias) begin
                    // Read the bit-band location with the original size
                    s_req_next   = 1'b1;
                    s_write_next = 1'b0;
                    s_lock_next  = m_write;
                    s_size_next  = m_size;
                    s_addr_next  = tgt_addr;
                    bitpos_next  = bit_pos;
                    wbit_next    = m_wdata[0];
                    alwr_next    = m_write;
                    state_next   = bbar_pkg::BBAR_RD;
                end else if (accept) begin
                    // Everything else goes through untouched
                    s_req_next   = 1'b1;
                    s_write_next = m_write;
                    s_lock_next  = 1'b0;
                    s_size_next  = m_size;
                    s_addr_next  = m_addr;
                    s_wdata_next = m_wdata;
                    state_next   = bbar_pkg::BBAR_PASS;
                end
            end
            bbar_pkg::BBAR_PASS: begin
                if (s_ack) begin
                    s_req_next   = 1'b0;
                    m_rdata_next = s_rdata;
                    m_done_next  = 1'b1;
                    state_next   = bbar_pkg::BBAR_IDLE;
                end
            end
            bbar_pkg::BBAR_RD: begin
                if (s_ack && alwr_reg) begin
                    // Write-back follows the read with no gap
                    s_write_next = 1'b1;
                    s_wdata_next = rmw;
                    state_next   = bbar_pkg::BBAR_WR;
                end else if (s_ack) begin
                    // Alias read shows only the selected bit
                    s_req_next   = 1'b0;
                    m_rdata_next = rd_bit ? bbar_pkg::ALIAS_ONE : bbar_pkg::RST_WORD;
                    m_done_next  = 1'b1;
                    state_next   = bbar_pkg::BBAR_IDLE;
                end
            end
            bbar_pkg::BBAR_WR: begin
                if (s_ack) begin
                    s_req_next   = 1'b0;
                    s_lock_next  = 1'b0;
                    s_write_next = 1'b0;
                    m_rdata_next = bbar_pkg::RST_WORD;
                    m_done_next  = 1'b1;
                    state_next   = bbar_pkg::BBAR_IDLE;
                end
            end
            default: begin
                state_next = bbar_pkg::BBAR_IDLE;
            end
        endcase
    end

    // State registers; ce freezes everything
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg   <= bbar_pkg::BBAR_IDLE;
            m_done_reg  <= 1'b0;
            m_err_reg   <= 1'b0;
            m_rdata_reg <= bbar_pkg::RST_WORD;
            s_req_reg   <= 1'b0;
            s_write_reg <= 1'b0;
            s_lock_reg  <= 1'b0;
            s_size_reg  <= bbar_pkg::SIZE_BYTE;
            s_addr_reg  <= bbar_pkg::RST_WORD;
            s_wdata_reg <= bbar_pkg::RST_WORD;
            bitpos_reg  <= 5'h0;
            wbit_reg    <= 1'b0;
            alwr_reg    <= 1'b0;
        end else if (ce) begin
            state_reg   <= state_next;
            m_done_reg  <= m_done_next;
            m_err_reg   <= m_err_next;
            m_rdata_reg <= m_rdata_next;
            s_req_reg   <= s_req_next;
            s_write_reg <= s_write_next;
            s_lock_reg  <= s_lock_next;
            s_size_reg  <= s_size_next;
            s_addr_reg  <= s_addr_next;
            s_wdata_reg <= s_wdata_next;
            bitpos_reg  <= bitpos_next;
            wbit_reg    <= wbit_next;
            alwr_reg    <= alwr_next;
        end
    end

    // Outputs straight from flops
    assign m_done  = m_done_reg;
    assign m_err   = m_err_reg;
    assign m_rdata = m_rdata_reg;
    assign s_req   = s_req_reg;
    assign s_write = s_write_reg;
    assign s_lock  = s_lock_reg;
    assign s_size  = s_size_reg;
    assign s_addr  = s_addr_reg;
    assign s_wdata = s_wdata_reg;

    // Checks on the driven outputs
    AST_FETCH_REFUSED: assert property (@(posedge clock) disable iff (!rst_n)
        (ce && accept && m_fetch && peri_alias) |=> (m_done && m_err && !s_req))
        else $error("Peripheral alias fetch not refused");

    AST_SRAM_FETCH_PLAIN: assert property (@(posedge clock) disable iff (!rst_n)
        (ce && accept && m_fetch && sram_alias) |=> (s_req && s_addr == $past(m_addr)))
        else $error("SRAM alias fetch was remapped");

    AST_ALIAS_TARGET: assert property (@(posedge clock) disable iff (!rst_n)
        (ce && accept && do_alias) |=> (s_req && !s_write && s_addr == $past(tgt_addr)))
        else $error("Alias access not sent to bit-band address");

    AST_SIZE_KEPT: assert property (@(posedge clock) disable iff (!rst_n)
        (ce && accept && !refuse) |=> (s_size == $past(m_size)))
        else $error("Underlying access size changed");

    AST_PLAIN_UNCHANGED: assert property (@(posedge clock) disable iff (!rst_n)
        (ce && accept && !refuse && !do_alias)
        |=> (s_addr == $past(m_addr) && s_wdata == $past(m_wdata) && s_write == $past(m_write)))
        else $error("Plain access altered");

    AST_RMW_BACK_TO_BACK: assert property (@(posedge clock) disable iff (!rst_n)
        (ce && state_reg == bbar_pkg::BBAR_RD && s_ack && alwr_reg)
        |=> (s_req && s_write && s_lock && s_addr == $past(s_addr)))
        else $error("Write-back not immediately after read");

    AST_WRITE_BIT: assert property (@(posedge clock) disable iff (!rst_n)
        (ce && state_reg == bbar_pkg::BBAR_RD && s_ack && alwr_reg)
        |=> (s_wdata[bitpos_reg] == wbit_reg
             && ((s_wdata ^ $past(s_rdata)) & ~(32'h0000_0001 << bitpos_reg)) == 32'h0000_0000))
        else $error("Alias write changed the wrong bits");

    AST_READ_VALUE: assert property (@(posedge clock) disable iff (!rst_n)
        (ce && state_reg == bbar_pkg::BBAR_RD && s_ack && !alwr_reg)
        |=> (m_done && !m_err && m_rdata == {31'h0, $past(s_rdata[bitpos_reg])}))
        else $error("Alias read value wrong");

    AST_WBIT_FROM_LSB: assert property (@(posedge clock) disable iff (!rst_n)
        (ce && accept && do_alias && m_write) |=> (wbit_reg == $past(m_wdata[0])))
        else $error("Alias write bit not taken from bit 0");

endmodule

`default_nettype wire

// ===== include/bbar_pkg.sv
// Constants shared by the bit-band alias remapper and its address mapper.
// Assumes a 32-bit byte-addressed little-endian memory map.
package bbar_pkg;

    // Address windows
    localparam logic [31:0] SRAM_BB_BASE    = 32'h2000_0000; // SRAM bit-band region start
    localparam logic [31:0] SRAM_BB_END     = 32'h2000_7FFF; // SRAM bit-band region end
    localparam logic [31:0] SRAM_AL_BASE    = 32'h2200_0000; // SRAM alias window start
    localparam logic [31:0] SRAM_AL_END     = 32'h220F_FFFF; // SRAM alias window end
    localparam logic [31:0] PERI_BB_BASE    = 32'h4000_0000; // Peripheral bit-band start
    localparam logic [31:0] PERI_BB_END     = 32'h400F_FFFF; // Peripheral bit-band end
    localparam logic [31:0] PERI_AL_BASE    = 32'h4200_0000; // Peripheral alias start
    localparam logic [31:0] PERI_AL_END     = 32'h43FF_FFFF; // Peripheral alias end

    // Alias address fields: word offset = byte offset * 32 + bit * 4
    localparam int          BYTE_OFS_LSB    = 5;             // Byte offset starts here
    localparam int          BIT_NUM_LSB     = 2;             // Bit number field start
    localparam int          BIT_NUM_W       = 3;             // Bit number 0-7

    // Access sizes
    localparam logic [1:0]  SIZE_BYTE       = 2'h0;          // 8-bit access
    localparam logic [1:0]  SIZE_HALF       = 2'h1;          // 16-bit access
    localparam logic [1:0]  SIZE_WORD       = 2'h2;          // 32-bit access

    // Reset and alias read values
    localparam logic [31:0] RST_WORD        = 32'h0000_0000; // Data and address regs
    localparam logic [31:0] ALIAS_ONE       = 32'h0000_0001; // Alias read of a set bit

    // Controller states
    typedef enum logic [1:0] {
        BBAR_IDLE,
        BBAR_PASS,
        BBAR_RD,
        BBAR_WR
    } bbar_state_t;

endpackage

// ===== verification/bbar_remap_tb_top.sv
// Self-checking bench for the bit-band alias remapper.
// Assumes the slave model on the slave port; stimulus changes at falling edges.
`timescale 1ns/1ps
`default_nettype none

module bbar_remap_tb_top;
    typedef struct {
        logic wr; logic fe; logic [1:0] sz; logic [31:0] addr; logic [31:0] wd; logic [31:0] rd;
        logic err; int n; logic [31:0] sa; logic [31:0] ma; logic [31:0] mv;
    } bbar_row_t;

    logic        clock = 1'b0;                          // 50 MHz
    logic        rst_n, ce, m_req, m_write, m_fetch;    // Master controls
    logic [1:0]  m_size;                                // Master size
    logic [31:0] m_addr, m_wdata;                       // Master address, data
    logic [3:0]  wait_cyc;                              // Slave stall
    logic        m_done, m_err, s_req, s_write, s_lock, s_ack;
    logic [1:0]  s_size;
    logic [31:0] m_rdata, s_addr, s_wdata, s_rdata;
    int          failures = 0;
    int          num_checks = 0;
    bbar_row_t   rows [14];                             // Ordinary cases

    bbar_remap i_bbar_remap (.clock(clock), .rst_n(rst_n), .ce(ce), .m_req(m_req), .m_write(m_write),
        .m_fetch(m_fetch), .m_size(m_size), .m_addr(m_addr), .m_wdata(m_wdata), .m_done(m_done),
        .m_err(m_err), .m_rdata(m_rdata), .s_req(s_req), .s_write(s_write), .s_lock(s_lock),
        .s_size(s_size), .s_addr(s_addr), .s_wdata(s_wdata), .s_ack(s_ack), .s_rdata(s_rdata));
    bbar_slave_model i_bbar_slave_model (.clock(clock), .rst_n(rst_n), .wait_cyc(wait_cyc), .s_req(s_req),
        .s_write(s_write), .s_lock(s_lock), .s_size(s_size), .s_addr(s_addr), .s_wdata(s_wdata),
        .s_ack(s_ack), .s_rdata(s_rdata));

    always #10 clock = ~clock;

    task automatic report_and_stop;
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_flag(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Raise a request; fields hold until the completion pulse
    task automatic drive(input bbar_row_t r);
        m_req = 1'b1;
        m_write = r.wr;
        m_fetch = r.fe;
        m_size = r.sz;
        m_addr = r.addr;
        m_wdata = r.wd;
    endtask

    // Bounded wait for completion, sampled mid-cycle
    task automatic wait_done;
        int k;
        for (k = 0; k < 60 && m_done !== 1'b1; k++) @(negedge clock);
        m_req = 1'b0;
        // A hung access is a mismatch of its own and ends the run
        if (k == 60) begin
            chk_flag("m_done before limit", 1'b1, m_done);
            report_and_stop();
        end
    endtask

    task automatic run_rows;
        int          b;       // Log depth before the row
        int          gap;     // Cycles between the two halves
        logic        both_lk; // Lock seen on both halves
        for (int i = 0; i < 14; i++) begin
            b = i_bbar_slave_model.log_q.size();
            @(negedge clock);
            drive(rows[i]);
            wait_done();
            chk_flag("m_err", rows[i].err, m_err);
            if (!rows[i].wr && !rows[i].err) chk_word("m_rdata", rows[i].rd, m_rdata);
            chk_word("slave count", 32'(rows[i].n), 32'(i_bbar_slave_model.log_q.size() - b));
            if (rows[i].n > 0) begin
                chk_word("s_addr", rows[i].sa, i_bbar_slave_model.log_q[b].addr);
                chk_word("s_size", {30'h0, rows[i].sz}, {30'h0, i_bbar_slave_model.log_q[b].size});
            end
            if (rows[i].n == 2) begin
                gap = i_bbar_slave_model.cyc_q[b+1] - i_bbar_slave_model.cyc_q[b];
                both_lk = i_bbar_slave_model.log_q[b].lock & i_bbar_slave_model.log_q[b+1].lock;
                chk_flag("rmw order", 1'b0, i_bbar_slave_model.log_q[b].wr);
                chk_word("rmw addr", rows[i].sa, i_bbar_slave_model.log_q[b+1].addr);
                chk_flag("rmw lock", 1'b1, both_lk);
                chk_word("rmw gap", 32'(wait_cyc) + 32'h1, 32'(gap));
            end
            if (rows[i].ma != 32'h0) begin
                chk_word("memory", rows[i].mv, i_bbar_slave_model.mem[rows[i].ma]);
            end
        end
    endtask

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        m_req = 1'b0;
        m_write = 1'b0;
        m_fetch = 1'b0;
        m_size = 2'h0;
        m_addr = 32'h0;
        m_wdata = 32'h0;
        wait_cyc = 4'h0;
        i_bbar_slave_model.mem[32'h2000_0000] = 32'h0000_0080;
        i_bbar_slave_model.mem[32'h2000_0004] = 32'h0004_0000;
        i_bbar_slave_model.mem[32'h2000_0010] = 32'h0000_00A5;
        i_bbar_slave_model.mem[32'h2200_001C] = 32'h1234_5678;
        i_bbar_slave_model.mem[32'h6000_0010] = 32'h1357_9BDF;
        i_bbar_slave_model.mem[32'h2210_0000] = 32'h2468_ACE0;
        // wr fe sz addr wd rd err n sa ma mv
        rows[0] = '{0, 0, 2'h2, 32'h2200_001C, 32'h0, 32'h1, 0, 1, 32'h2000_0000, 32'h0, 32'h0};
        rows[1] = '{0, 0, 2'h0, 32'h2200_0000, 32'h0, 32'h0, 0, 1, 32'h2000_0000, 32'h0, 32'h0};
        rows[2] = '{1, 0, 2'h0, 32'h2200_0004, 32'hFFFF_FFFF, 32'h0, 0, 2,
                    32'h2000_0000, 32'h2000_0000, 32'h82};
        rows[3] = '{1, 0, 2'h2, 32'h2200_0004, 32'h0000_000E, 32'h0, 0, 2,
                    32'h2000_0000, 32'h2000_0000, 32'h80};
        rows[4] = '{1, 0, 2'h1, 32'h4200_00AC, 32'h1, 32'h0, 0, 2, 32'h4000_0004, 32'h4000_0004, 32'h0800};
        rows[5] = '{0, 0, 2'h2, 32'h4200_00AC, 32'h0, 32'h1, 0, 1, 32'h4000_0004, 32'h0, 32'h0};
        rows[6] = '{0, 1, 2'h2, 32'h4200_0000, 32'h0, 32'h0, 1, 0, 32'h0, 32'h0, 32'h0};
        rows[7] = '{0, 1, 2'h2, 32'h2200_001C, 32'h0, 32'h1234_5678, 0, 1, 32'h2200_001C, 32'h0, 32'h0};
        rows[8] = '{0, 0, 2'h2, 32'h4000_0004, 32'h0, 32'h0000_0800, 0, 1, 32'h4000_0004, 32'h0, 32'h0};
        rows[9] = '{1, 0, 2'h0, 32'h2000_0013, 32'h5A00_0000, 32'h0, 0, 1,
                    32'h2000_0013, 32'h2000_0010, 32'h5A00_00A5};
        rows[10] = '{0, 0, 2'h2, 32'h6000_0010, 32'h0, 32'h1357_9BDF, 0, 1, 32'h6000_0010, 32'h0, 32'h0};
        rows[11] = '{1, 0, 2'h2, 32'h220F_FFFC, 32'h3, 32'h0, 0, 2,
                     32'h2000_7FFC, 32'h2000_7FFC, 32'h8000_0000};
        rows[12] = '{0, 0, 2'h2, 32'h2210_0000, 32'h0, 32'h2468_ACE0, 0, 1, 32'h2210_0000, 32'h0, 32'h0};
        rows[13] = '{0, 0, 2'h1, 32'h2200_00C8, 32'h0, 32'h1, 0, 1, 32'h2000_0006, 32'h0, 32'h0};
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        chk_flag("m_done at reset", 1'b0, m_done);
        chk_flag("s_req at reset", 1'b0, s_req);
        chk_word("m_rdata at reset", 32'h0, m_rdata);
        run_rows();
        wait_cyc = 4'h3;
        run_rows();
        // Request under a low clock enable must not be taken
        @(negedge clock);
        ce = 1'b0;
        drive(rows[0]);
        repeat (3) @(negedge clock);
        chk_flag("s_req frozen", 1'b0, s_req);
        ce = 1'b1;
        wait_done();
        chk_word("m_rdata after enable", 32'h1, m_rdata);
        // Reset in the read half of an alias write leaves memory untouched
        wait_cyc = 4'h6;
        @(negedge clock);
        drive(rows[2]);
        repeat (3) @(negedge clock);
        chk_flag("s_lock mid sequence", 1'b1, s_lock);
        rst_n = 1'b0;
        m_req = 1'b0;
        repeat (2) @(negedge clock);
        chk_flag("s_req in reset", 1'b0, s_req);
        chk_flag("s_lock in reset", 1'b0, s_lock);
        rst_n = 1'b1;
        chk_word("no partial write", 32'h0000_0080, i_bbar_slave_model.mem[32'h2000_0000]);
        wait_cyc = 4'h0;
        @(negedge clock);
        drive(rows[0]);
        wait_done();
        chk_word("m_rdata after reset", 32'h1, m_rdata);
        report_and_stop();
    end
endmodule

`default_nettype wire

// ===== verification/bbar_slave_model.sv
// Behavioural memory slave for the remapper's slave port, with a logged history.
// Assumes held requests; answers each with a one-cycle ack after wait_cyc idle cycles.
`timescale 1ns/1ps
`default_nettype none

module bbar_slave_model (
    input  wire logic        clock,    // System clock
    input  wire logic        rst_n,    // Synchronous reset, active low
    input  wire logic [3:0]  wait_cyc, // Stall cycles before each ack
    input  wire logic        s_req,    // Request, held until ack
    input  wire logic        s_write,  // Direction
    input  wire logic        s_lock,   // Locked sequence marker
    input  wire logic [1:0]  s_size,   // Access size
    input  wire logic [31:0] s_addr,   // Byte address
    input  wire logic [31:0] s_wdata,  // Write data, lanes by address
    output logic             s_ack,    // One-cycle completion
    output logic [31:0]      s_rdata   // Read data, valid with ack only
);
    typedef struct packed {
        logic        wr;
        logic        lock;
        logic [1:0]  size;
        logic [31:0] addr;
    } bbar_acc_t;

    logic [31:0] mem [logic [31:0]]; // Sparse store by word address
    bbar_acc_t   log_q [$];          // Completed accesses, oldest first
    int          cyc_q [$];          // Cycle stamp of each completion
    int          cyc;                // Falling-edge count
    int          stall;              // Idle cycles on current access
    logic [31:0] key;                // Word address of the access
    logic [31:0] word;               // Word being read or merged
    logic [3:0]  lanes;              // Lanes touched by a write

    assign key = {s_addr[31:2], 2'h0};
    // Little-endian lanes from size and low address bits
    assign lanes = (s_size == 2'h2) ? 4'hF : (s_size == 2'h1) ? (s_addr[1] ? 4'hC : 4'h3) : (4'h1 << s_addr[1:0]);

    initial begin
        s_ack = 1'b0;
        s_rdata = 32'h0;
        stall = 0;
        cyc = 0;
    end

    // Answer just after the falling edge; the remapper samples at the rising one
    always @(negedge clock) begin
        cyc = cyc + 1;
        word = mem.exists(key) ? mem[key] : 32'h0;
        if (rst_n && s_req && stall >= int'(wait_cyc)) begin
            s_ack = 1'b1;
            s_rdata = word;
            stall = 0;
            // Only the addressed lanes change on a write
            for (int i = 0; i < 4; i++) if (s_write && lanes[i]) word[8*i +: 8] = s_wdata[8*i +: 8];
            if (s_write) mem[key] = word;
            log_q.push_back({s_write, s_lock, s_size, s_addr});
            cyc_q.push_back(cyc);
        end else begin
            s_ack = 1'b0;
            // Idle data toggles so a stale value never passes for a reply
            s_rdata = ~s_rdata;
            stall = (rst_n && s_req) ? stall + 1 : 0;
        end
    end
endmodule

`default_nettype wire
